// ---- rtl/omf_ctrl.sv ----
// Operating mode register and FIFO package writer
//
// Behaviour
// - Select codes 0,1,3: standby, proximity, sample
// - Code 0xF idle: only bias follows setting
// - Proximity, content 1: intensity only, 2 bytes
// - Proximity, content 3: x, y, intensity
// - Proximity, other content: nothing written
// - Gesture code 2: always 4 bytes
// - Guard set: drop package lacking whole room
// - Marker set: first word LSB 1, others 0
// - Bit 10 enables proximity to sample switch
// - Content, guard, marker reset zero, read/write
// - Select field bits [3:0] at 0x45, resets zero
`timescale 1ns/1ps
module omf_ctrl
  import omf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Measurement engine side
  input wire logic meas_valid,
  input wire omf_meas_t meas,
  input wire logic near_event,
  input wire logic bias_keep,
  output omf_power_t power,
  output logic mode_switched,
  // FIFO storage side
  input wire logic [OMF_FREE_W-1:0] fifo_free,
  output logic fifo_wr,
  output logic [15:0] fifo_wdata,
  output logic pkg_dropped,
  output logic pkg_busy
);

  omf_ctrl_t ctrl;
  omf_ctrl_t next_ctrl;
  omf_layout_t layout;
  logic [2:0] pkg_words;

  omf_pk_state_t state;
  omf_pk_state_t next_state;
  // Frozen copy of the package being sent
  omf_layout_t pk_layout;
  omf_meas_t pk_meas;
  logic [2:0] pk_len;
  logic [2:0] pk_idx;
  logic [2:0] next_idx;
  logic pk_marker;

  // Decode and handshake helpers
  logic wr_hit;
  logic auto_fire;
  logic room_ok;
  logic accept;
  logic start;
  logic last_word;
  logic first_word;

  // Word of a package at a given position for a given layout
  function automatic logic [15:0] pick_word(
    input omf_layout_t lay,
    input logic [2:0] idx,
    input omf_meas_t m
  );
    logic [15:0] w;
    w = m.i;
    unique case (lay)
      OMF_LAY_I: w = m.i;
      OMF_LAY_XY: begin
        // Two-word package: x leads, y follows
        if (idx == 3'h0) begin
          w = m.x;
        end else begin
          w = m.y;
        end
      end
      OMF_LAY_XYI: begin
        if (idx == 3'h0) begin
          w = m.x;
        end else if (idx == 3'h1) begin
          w = m.y;
        end else begin
          w = m.i;
        end
      end
      OMF_LAY_NONE: w = m.i;
    endcase
    return w;
  endfunction

  // Apply the package start marker to the lowest bit
  function automatic logic [15:0] mark_word(
    input logic [15:0] w,
    input logic en,
    input logic first
  );
    logic [15:0] r;
    r = w;
    if (en) begin
      r[0] = first;
    end
    return r;
  endfunction

  // Only the one control offset is mapped on this port
  function automatic logic is_ctrl_addr(
    input logic [7:0] a
  );
    return a == OMF_ADDR_CTRL;
  endfunction

  omf_mode_decode u_decode (
    .ctrl(ctrl),
    .bias_keep(bias_keep),
    .power(power),
    .layout(layout),
    .pkg_words(pkg_words)
  );

  // ---------------- Control register ----------------

  assign wr_hit = reg_wr && is_ctrl_addr(reg_addr);

  // Hardware switch only fires from proximity with the enable set
  assign auto_fire = ctrl.auto_switch_from_near_detect && near_event &&
                     (ctrl.operation_select == OMF_OP_NEAR);

  always_comb begin
    next_ctrl = ctrl;
    if (wr_hit) begin
      next_ctrl = omf_ctrl_t'(reg_wdata & OMF_CTRL_WMASK);
    end
    // The switch wins over a host write in the same cycle
    if (auto_fire) begin
      next_ctrl.operation_select = OMF_OP_SAMPLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= omf_ctrl_t'(OMF_CTRL_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Pulse tells the engine that the mode changed under it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_switched <= 1'b0;
    end else begin
      mode_switched <= auto_fire;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Read data holds until the next read; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (is_ctrl_addr(reg_addr)) begin
        reg_rdata <= 16'(ctrl) & OMF_CTRL_WMASK;
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // ---------------- Package writer ----------------

  // Room is judged once per package, so a package is never split
  assign room_ok = !ctrl.guard ||
                   (fifo_free >= OMF_FREE_W'(pkg_words));

  // A sample arriving while a package is still being sent is lost:
  // the engine delivers at most one sample per few cycles.
  assign accept = meas_valid && (state == OMF_PK_WAIT) &&
                  (pkg_words != OMF_WORDS_NONE);

  // Only a sample that fits, or is unguarded, opens a package
  assign start = accept && room_ok;

  // Length is frozen, so the end cannot move in mid-package
  assign last_word = (pk_idx == pk_len - 3'h1);

  assign first_word = (pk_idx == 3'h0);

  always_comb begin
    next_state = state;
    unique case (state)
      OMF_PK_WAIT: begin
        if (start) begin
          next_state = OMF_PK_SEND;
        end
      end
      OMF_PK_SEND: begin
        if (last_word) begin
          next_state = OMF_PK_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OMF_PK_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Package format is frozen at acceptance; a host write in mid-package
  // only affects the next one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_layout <= OMF_LAY_NONE;
      pk_len <= OMF_WORDS_NONE;
    end else if (start) begin
      pk_layout <= layout;
      pk_len <= pkg_words;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_meas <= '0;
    end else if (start) begin
      pk_meas <= meas;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_marker <= 1'b0;
    end else if (start) begin
      pk_marker <= ctrl.marker;
    end
  end

  // Index restarts in every wait cycle, so each package opens at word 0
  always_comb begin
    next_idx = pk_idx + 3'h1;
    if (state == OMF_PK_WAIT) begin
      next_idx = 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pk_idx <= 3'h0;
    end else begin
      pk_idx <= next_idx;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_wr <= 1'b0;
    end else begin
      fifo_wr <= (state == OMF_PK_SEND);
    end
  end

  // Data is only loaded with a word, so it holds between packages
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_wdata <= 16'h0000;
    end else if (state == OMF_PK_SEND) begin
      fifo_wdata <= mark_word(pick_word(pk_layout, pk_idx, pk_meas),
                              pk_marker, first_word);
    end
  end

  // Whole package discarded when the guard finds too little room
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkg_dropped <= 1'b0;
    end else begin
      pkg_dropped <= accept && !room_ok;
    end
  end

  // New samples are ignored while this is high
  assign pkg_busy = (state == OMF_PK_SEND);

endmodule // omf_ctrl

// ---- rtl/omf_mode_decode.sv ----
// Decode of the operation select and content fields
`timescale 1ns/1ps
module omf_mode_decode
  import omf_pkg::*;
(
  input wire omf_ctrl_t ctrl,
  input wire logic bias_keep,
  output omf_power_t power,
  output omf_layout_t layout,
  output logic [2:0] pkg_words
);

  always_comb begin
    power = '0;
    layout = OMF_LAY_NONE;
    unique case (ctrl.operation_select)
      OMF_OP_STANDBY: begin
        power = '0;
      end
      OMF_OP_NEAR: begin
        power.core_on = 1'b1;
        power.near_run = 1'b1;
        power.bias_on = 1'b1;
        if (ctrl.content == OMF_CONTENT_I) begin
          layout = OMF_LAY_I;
        end else if (ctrl.content == OMF_CONTENT_XYI) begin
          layout = OMF_LAY_XYI;
        end else begin
          layout = OMF_LAY_NONE;
        end
      end
      OMF_OP_GESTURE: begin
        // Unused code still packs 4 bytes regardless of content
        power.core_on = 1'b1;
        power.gesture_run = 1'b1;
        power.bias_on = 1'b1;
        layout = OMF_LAY_XY;
      end
      OMF_OP_SAMPLE: begin
        power.core_on = 1'b1;
        power.sample_run = 1'b1;
        power.bias_on = 1'b1;
        layout = OMF_LAY_XYI;
      end
      OMF_OP_IDLE: begin
        // Only the bias follows its own setting, from bias_keep; all other power bits stay off
        power.bias_on = bias_keep;
      end
      default: begin
        power = '0;
        layout = OMF_LAY_NONE;
      end
    endcase
  end

  always_comb begin
    unique case (layout)
      OMF_LAY_NONE: pkg_words = OMF_WORDS_NONE;
      OMF_LAY_I: pkg_words = OMF_WORDS_I;
      OMF_LAY_XY: pkg_words = OMF_WORDS_XY;
      OMF_LAY_XYI: pkg_words = OMF_WORDS_XYI;
    endcase
  end

endmodule // omf_mode_decode

// ---- rtl/omf_pkg.sv ----
// Package: constants and types of the mode and FIFO format control
package omf_pkg;

  // Register map
  localparam logic [7:0] OMF_ADDR_CTRL = 8'h45;
  localparam logic [15:0] OMF_CTRL_RESET = 16'h0000;
  localparam logic [15:0] OMF_CTRL_WMASK = 16'h07FF;

  // Field positions inside the control register
  localparam int OMF_OPSEL_LSB = 0;
  localparam int OMF_CONTENT_LSB = 4;
  localparam int OMF_GUARD_BIT = 8;
  localparam int OMF_MARKER_BIT = 9;
  localparam int OMF_AUTO_BIT = 10;

  // Operation select codes
  localparam logic [3:0] OMF_OP_STANDBY = 4'h0;
  localparam logic [3:0] OMF_OP_NEAR = 4'h1;
  localparam logic [3:0] OMF_OP_GESTURE = 4'h2;
  localparam logic [3:0] OMF_OP_SAMPLE = 4'h3;
  localparam logic [3:0] OMF_OP_IDLE = 4'hF;

  // FIFO content codes in proximity mode
  localparam logic [3:0] OMF_CONTENT_I = 4'h1;
  localparam logic [3:0] OMF_CONTENT_XYI = 4'h3;

  // Words (16 bit) per package for each layout
  localparam logic [2:0] OMF_WORDS_I = 3'h1;
  localparam logic [2:0] OMF_WORDS_XY = 3'h2;
  localparam logic [2:0] OMF_WORDS_XYI = 3'h3;
  localparam logic [2:0] OMF_WORDS_NONE = 3'h0;

  // Width of the free space count reported by the FIFO storage
  localparam int OMF_FREE_W = 8;

  typedef enum logic [1:0] {
    OMF_LAY_NONE = 2'h0,
    OMF_LAY_I = 2'h1,
    OMF_LAY_XY = 2'h2,
    OMF_LAY_XYI = 2'h3
  } omf_layout_t;

  typedef enum logic {
    OMF_PK_WAIT = 1'b0,
    OMF_PK_SEND = 1'b1
  } omf_pk_state_t;

  // Bit layout of the control register, msb first
  typedef struct packed {
    logic [4:0] reserved;
    logic auto_switch_from_near_detect;
    logic marker;
    logic guard;
    logic [3:0] content;
    logic [3:0] operation_select;
  } omf_ctrl_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] i;
  } omf_meas_t;

  typedef struct packed {
    logic core_on;
    logic near_run;
    logic gesture_run;
    logic sample_run;
    logic bias_on;
  } omf_power_t;

endpackage

// ---- verif/omf_ctrl_asserts.sv ----
// Assertion checker bound to the mode and FIFO format control
`timescale 1ns/1ps
module omf_ctrl_asserts
  import omf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic near_event,
  input wire logic bias_keep,
  input wire omf_power_t power,
  input wire logic mode_switched,
  input wire logic fifo_wr,
  input wire logic pkg_dropped,
  input wire logic pkg_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A write without a same-cycle auto switch that could override the select field
  sequence s_wr;
    reg_wr && reg_addr == OMF_ADDR_CTRL && !near_event;
  endsequence
  sequence s_rd;
    reg_rd && !reg_wr && reg_addr == OMF_ADDR_CTRL;
  endsequence
  chk_standby_power: assert property (s_wr ##0 reg_wdata[3:0] == 4'h0 |=> power == 5'h00)
    else $error("standby power wrong");
  chk_near_run: assert property (s_wr ##0 reg_wdata[3:0] == 4'h1 |=> power.near_run)
    else $error("proximity run missing");
  chk_sample_run: assert property (s_wr ##0 reg_wdata[3:0] == 4'h3 |=> power.sample_run)
    else $error("sample run missing");
  chk_idle_bias: assert property (s_wr ##0 reg_wdata[3:0] == 4'hF |=> power == {4'h0, bias_keep})
    else $error("idle power wrong");
  chk_drop_no_write: assert property (pkg_dropped |-> !fifo_wr)
    else $error("word written with a dropped package");
  chk_word_in_pkg: assert property (fifo_wr |-> $past(pkg_busy))
    else $error("word written outside a package");
  chk_auto_sample: assert property (mode_switched |-> power.sample_run)
    else $error("switch without sample mode");
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  chk_write_readback: assert property (s_wr ##1 !reg_wr && !near_event ##1 s_rd
    |=> reg_rdata == ($past(reg_wdata, 3) & OMF_CTRL_WMASK))
    else $error("read back differs from write");
endmodule // omf_ctrl_asserts

bind omf_ctrl omf_ctrl_asserts i_chk(.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .reg_rvalid, .near_event, .bias_keep, .power, .mode_switched, .fifo_wr,
  .pkg_dropped, .pkg_busy);

// ---- verif/omf_fifo_model.sv ----
// FIFO storage model that records every word written by the block
`timescale 1ns/1ps
module omf_fifo_model
  import omf_pkg::*;
#(parameter int DEPTH = 8)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fifo_wr,
  input wire logic [15:0] fifo_wdata,
  input wire logic drain,
  output logic [OMF_FREE_W-1:0] fifo_free
);
  int cnt;
  logic [15:0] mem [0:63];
  // Free space saturates at zero, so an unguarded overrun is still recorded
  assign fifo_free = OMF_FREE_W'(cnt >= DEPTH ? 0 : DEPTH - cnt);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
    end else if (drain) begin
      cnt <= 0;
    end else if (fifo_wr) begin
      mem[cnt] <= fifo_wdata;
      cnt <= cnt + 1;
    end
  end
endmodule // omf_fifo_model

// ---- verif/tb.sv ----
// Testbench for the mode and FIFO format control
`timescale 1ns/1ps
module tb;
  import omf_pkg::*;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, meas_valid = 0;
  logic near_event = 0, bias_keep = 0, drain = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, fifo_wdata;
  logic [OMF_FREE_W-1:0] fifo_free;
  logic reg_rvalid, mode_switched, fifo_wr, pkg_dropped, pkg_busy;
  // Odd y and i show the marker clearing bit 0
  omf_meas_t meas = {16'h1234, 16'h5679, 16'h9ABD};
  omf_power_t power;
  int fails = 0, compares = 0;
  int drops = 0, switches = 0;
  always #10 ref_clk = ~ref_clk;
  // Pulse outputs are counted at every edge so none slips past a check
  always @(posedge ref_clk) begin
    if (pkg_dropped === 1'b1) begin
      drops++;
    end
    if (mode_switched === 1'b1) begin
      switches++;
    end
  end
  omf_ctrl i_dut(.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .meas_valid, .meas, .near_event, .bias_keep, .power, .mode_switched,
    .fifo_free, .fifo_wr, .fifo_wdata, .pkg_dropped, .pkg_busy);
  omf_fifo_model i_fifo(.ref_clk, .rst_n, .fifo_wr, .fifo_wdata, .drain, .fifo_free);
  task automatic end_of_test;
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Ends just after the edge that took the write, so its effect is settled
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk("read valid", 16'(reg_rvalid), 16'h0001);
    d = reg_rdata;
  endtask
  // One measurement; e holds the expected words, first word in the top bits
  task automatic pk(input logic [15:0] c, input int n, input logic [47:0] e);
    int b;
    wr(OMF_ADDR_CTRL, c);
    b = i_fifo.cnt;
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    @(posedge ref_clk);
    chk("package busy", 16'(pkg_busy), 16'(n != 0));
    repeat (5) @(posedge ref_clk);
    chk("word count", 16'(i_fifo.cnt - b), 16'(n));
    for (int k = 0; k < n; k++) begin
      chk("fifo word", i_fifo.mem[b + k], e[47 - 16 * k -: 16]);
    end
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    end_of_test;
  end
  initial begin
    logic [15:0] d;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    bias_keep <= 1'b1;
    rd(OMF_ADDR_CTRL, d);
    chk("ctrl reset", d, OMF_CTRL_RESET);
    wr(OMF_ADDR_CTRL, 16'hFFFF);
    rd(OMF_ADDR_CTRL, d);
    chk("ctrl rw", d, 16'h07FF);
    rd(8'h44, d);
    chk("unmapped read", d, 16'h0000);
    wr(OMF_ADDR_CTRL, 16'h000F);
    chk("idle power", 16'(power), 16'h0001);
    wr(OMF_ADDR_CTRL, 16'h0000);
    chk("standby power", 16'(power), 16'h0000);
    wr(OMF_ADDR_CTRL, 16'h0001);
    chk("near run", 16'(power.near_run), 16'h0001);
    wr(OMF_ADDR_CTRL, 16'h0003);
    chk("sample run", 16'(power.sample_run), 16'h0001);
    pk(16'h0011, 1, {16'h9ABD, 32'h0});
    pk(16'h0031, 3, {16'h1234, 16'h5679, 16'h9ABD});
    pk(16'h0021, 0, 48'h0);
    pk(16'h0012, 2, {16'h1234, 16'h5679, 16'h0});
    pk(16'h0231, 3, {16'h1235, 16'h5678, 16'h9ABC});
    @(posedge ref_clk);
    drain <= 1'b1;
    @(posedge ref_clk);
    drain <= 1'b0;
    pk(16'h0131, 3, {16'h1234, 16'h5679, 16'h9ABD});
    pk(16'h0131, 3, {16'h1234, 16'h5679, 16'h9ABD});
    pk(16'h0131, 0, 48'h0);
    pk(16'h0112, 2, {16'h1234, 16'h5679, 16'h0});
    pk(16'h0031, 3, {16'h1234, 16'h5679, 16'h9ABD});
    chk("drop count", 16'(drops), 16'h0001);
    for (int k = 0; k < 2; k++) begin
      wr(OMF_ADDR_CTRL, k ? 16'h0001 : 16'h0401);
      @(posedge ref_clk);
      near_event <= 1'b1;
      @(posedge ref_clk);
      near_event <= 1'b0;
      rd(OMF_ADDR_CTRL, d);
      chk("auto switch", d, k ? 16'h0001 : 16'h0403);
    end
    chk("switch count", 16'(switches), 16'h0001);
    wr(OMF_ADDR_CTRL, 16'h07F1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("reset power", 16'(power), 16'h0000);
    rd(OMF_ADDR_CTRL, d);
    chk("ctrl mid reset", d, OMF_CTRL_RESET);
    end_of_test;
  end
endmodule // tb
